// *** hw/ltpg_top.v ***
// LVDS test pattern generator: pattern substitution, FIFO and lane serializers
`timescale 1ns/1ps
`default_nettype none
`include "ltpg_map.vh"

module ltpg_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Avalon-MM slave
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  // Converter samples, one word per lane, qualified by sample_valid_i
  input  wire [55:0] sample_data_i,
  input  wire        sample_valid_i,
  output reg         sample_ready_o,
  // Link pins
  input  wire        link_clk_i,
  input  wire        transmit_trigger_pin_i,
  output reg  [3:0]  lane_data_o,
  output reg         frame_lane_o
);
  localparam S  = `LTPG_SER;
  localparam NL = `LTPG_LANES;
  localparam [S-1:0] RAMP_STEP = 14'h0001 << (`LTPG_SER - `LTPG_RES);
  localparam [S-1:0] NEG_FS    = 14'h0000;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  reg  [31:0] ctrl_ff;
  reg  [31:0] lane_sel_ff;
  reg  [31:0] custom_ff;
  reg  [31:0] nxt_ctrl;
  reg  [31:0] nxt_lane_sel;
  reg  [31:0] nxt_custom;
  reg         acked_ff;
  wire        acc;
  integer     b;
  // Status sources, read back through STATUS
  reg  [S-1:0] ramp_ff;
  reg          toggle_ff;
  wire         fifo_full;

  // ---------------------------------------------------------------
  // Control field decode
  // ---------------------------------------------------------------
  wire [2:0]    common_pattern_select     = ctrl_ff[`LTPG_CTRL_COMMON_LSB +: 3];
  wire          per_lane_select_enable    = ctrl_ff[`LTPG_CTRL_PERLANE];
  wire          global_random_select      = ctrl_ff[`LTPG_CTRL_GBL_RAND];
  wire          random_seq_enable         = ctrl_ff[`LTPG_CTRL_RAND_EN];
  wire          random_seq_length_select  = ctrl_ff[`LTPG_CTRL_RAND_LEN];
  wire          random_seq_reset          = ctrl_ff[`LTPG_CTRL_RAND_RST];
  wire [2:0]    frame_lane_pattern_select = ctrl_ff[`LTPG_CTRL_FRAME_LSB +: 3];
  wire          frame_lane_random_select  = ctrl_ff[`LTPG_CTRL_FRAME_RAND];
  wire          sync_bit                  = ctrl_ff[`LTPG_CTRL_SYNC];
  wire [NL-1:0] lane_random_enable        = ctrl_ff[`LTPG_CTRL_LANE_RAND +: NL];

  // ---------------------------------------------------------------
  // Bus handshake and register writes
  // ---------------------------------------------------------------
  // One wait state: waitrequest drops one cycle after the request is seen
  // Writes land on the answer edge, so a read never sees a half-done write
  assign acc = (avs_read_i || avs_write_i) && !acked_ff;

  always @* begin
    nxt_ctrl     = ctrl_ff;
    nxt_lane_sel = lane_sel_ff;
    nxt_custom   = custom_ff;
    if (avs_write_i && acked_ff) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (avs_byteenable_i[b]) begin
          case (avs_address_i)
            `LTPG_REG_CTRL: begin
              nxt_ctrl[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
            end
            `LTPG_REG_LANE_SEL: begin
              nxt_lane_sel[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
            end
            `LTPG_REG_CUSTOM: begin
              nxt_custom[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_ff           <= `LTPG_RST_CTRL;
      lane_sel_ff       <= `LTPG_RST_LANE_SEL;
      custom_ff         <= `LTPG_RST_CUSTOM;
      acked_ff          <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      // Unused upper bits of lane_sel_ff and custom_ff are never stored, so they always read back as zero
      lane_sel_ff <= {20'h00000, nxt_lane_sel[11:0]};
      custom_ff   <= {16'h0000, nxt_custom[15:0]};
      acked_ff    <= acc;
      avs_waitrequest_o <= !acc;
      if (acc && avs_read_i) begin
        case (avs_address_i)
          `LTPG_REG_CTRL:     avs_readdata_o <= ctrl_ff;
          `LTPG_REG_LANE_SEL: avs_readdata_o <= lane_sel_ff;
          `LTPG_REG_CUSTOM:   avs_readdata_o <= custom_ff;
          `LTPG_REG_STATUS:   avs_readdata_o <= {16'h0000, ramp_ff, toggle_ff, fifo_full};
          default:            avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin input synchronisers (three stages, change on 2nd==3rd)
  // ---------------------------------------------------------------
  reg  [2:0] lclk_sync_ff;
  reg  [2:0] trig_sync_ff;
  reg        lclk_ff;
  reg        trig_ff;
  reg        trig_d_ff;
  reg        sync_bit_d_ff;
  reg        rand_rst_d_ff;
  wire       lclk_rise;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      lclk_sync_ff  <= 3'h0;
      trig_sync_ff  <= 3'h0;
      lclk_ff       <= 1'b0;
      trig_ff       <= 1'b0;
      trig_d_ff     <= 1'b0;
      sync_bit_d_ff <= 1'b0;
      rand_rst_d_ff <= 1'b0;
    end else begin
      lclk_sync_ff  <= {lclk_sync_ff[1:0], link_clk_i};
      trig_sync_ff  <= {trig_sync_ff[1:0], transmit_trigger_pin_i};
      if (lclk_sync_ff[1] == lclk_sync_ff[2]) begin
        lclk_ff <= lclk_sync_ff[2];
      end
      if (trig_sync_ff[1] == trig_sync_ff[2]) begin
        trig_ff <= trig_sync_ff[2];
      end
      trig_d_ff     <= trig_ff;
      sync_bit_d_ff <= sync_bit;
      rand_rst_d_ff <= random_seq_reset;
    end
  end

  assign lclk_rise = (lclk_sync_ff[1] == lclk_sync_ff[2]) && lclk_sync_ff[2] && !lclk_ff;

  // ---------------------------------------------------------------
  // Restart detection
  // ---------------------------------------------------------------
  // Restart on trigger rising edge or on the falling edge of the sync bit (set then clear)
  // Acting on the clear lets software park the bit set without freezing the patterns
  wire restart  = (trig_ff && !trig_d_ff) || (sync_bit_d_ff && !sync_bit);
  wire prbs_rst = restart || (random_seq_reset && !rand_rst_d_ff);

  // ---------------------------------------------------------------
  // Pattern sources, advanced once per conversion word
  // ---------------------------------------------------------------
  reg  [22:0]  prbs23_ff;
  reg  [8:0]   prbs9_ff;
  wire         conv_tick;
  wire [15:0]  prbs_word;
  // Low custom bits beyond the serialization factor are dropped
  wire [S-1:0] custom_word = custom_ff[15 -: S];

  // Random word from the MSB side of the selected generator
  assign prbs_word = random_seq_length_select ? {prbs9_ff, 7'h00} : prbs23_ff[22:7];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ramp_ff   <= NEG_FS;
      toggle_ff <= 1'b0;
      prbs23_ff <= `LTPG_PRBS_SEED23;
      prbs9_ff  <= `LTPG_PRBS_SEED9;
    end else begin
      if (restart) begin
        ramp_ff   <= NEG_FS;
        toggle_ff <= 1'b0;
      end else if (conv_tick) begin
        ramp_ff   <= ramp_ff + RAMP_STEP;
        toggle_ff <= !toggle_ff;
      end
      // Generators step per accepted word; a reseed lines them up with the receiver
      if (prbs_rst) begin
        prbs23_ff <= `LTPG_PRBS_SEED23;
        prbs9_ff  <= `LTPG_PRBS_SEED9;
      end else if (conv_tick) begin
        prbs23_ff <= {prbs23_ff[21:0], prbs23_ff[22] ^ prbs23_ff[17]};
        prbs9_ff  <= {prbs9_ff[7:0], prbs9_ff[8] ^ prbs9_ff[4]};
      end
    end
  end

  function [S-1:0] pat_word;
    input [2:0]   sel;
    input [S-1:0] sample;
    input         rnd;
    begin
      case (sel)
        `LTPG_PAT_ZEROS:  pat_word = {S{1'b0}};
        `LTPG_PAT_ONES:   pat_word = {S{1'b1}};
        `LTPG_PAT_DESKEW: pat_word = `LTPG_DESKEW_WORD;
        `LTPG_PAT_SYNC:   pat_word = `LTPG_SYNC_WORD;
        `LTPG_PAT_CUSTOM: pat_word = rnd ? prbs_word[15 -: S] : custom_word;
        `LTPG_PAT_RAMP:   pat_word = rnd ? prbs_word[15 -: S] : ramp_ff;
        `LTPG_PAT_TOGGLE: pat_word = {S{toggle_ff}};
        default:          pat_word = sample;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Substitution and FIFO
  // ---------------------------------------------------------------
  wire [NL*S-1:0] sub_word;
  wire            fifo_in_ready;
  wire            ser_valid;
  wire [NL*S-1:0] ser_data;
  reg             ser_take;

  genvar g;
  generate
    for (g = 0; g < NL; g = g + 1) begin : g_lane
      wire [2:0] sel = per_lane_select_enable ? lane_sel_ff[g*3 +: 3] : common_pattern_select;
      wire       rnd = random_seq_enable &&
                       (per_lane_select_enable ? lane_random_enable[g] : global_random_select);
      assign sub_word[g*S +: S] = pat_word(sel, sample_data_i[g*S +: S], rnd);
    end
  endgenerate

  assign conv_tick = sample_valid_i && fifo_in_ready;
  assign fifo_full = !fifo_in_ready;

  // Registered copy of FIFO ready: a source that waits for it before each
  // offer gives up some throughput, but the output comes from a flip-flop
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sample_ready_o <= 1'b0;
    end else begin
      sample_ready_o <= fifo_in_ready;
    end
  end

  // The FIFO absorbs the rate gap: a sample per clock in, a word per 14 link edges out
  ltpg_fifo #(
    .WIDTH (NL*S),
    .DEPTH (`LTPG_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (sub_word),
    .out_valid_o (ser_valid),
    .out_ready_i (ser_take),
    .out_data_o  (ser_data)
  );

  // ---------------------------------------------------------------
  // Serializer: one bit per link clock rising edge, MSB first
  // ---------------------------------------------------------------
  reg  [NL*S-1:0] shift_ff;
  reg  [S-1:0]    frame_shift_ff;
  reg  [3:0]      bit_cnt_ff;
  reg             busy_ff;
  wire [S-1:0]    frame_word;
  wire            frame_rnd = frame_lane_random_select && random_seq_enable;
  integer         l;

  // Frame word idles as the usual half-high frame marker
  assign frame_word = (frame_lane_pattern_select == `LTPG_PAT_NORMAL) ? `LTPG_SYNC_WORD :
                      pat_word(frame_lane_pattern_select, `LTPG_SYNC_WORD, frame_rnd);

  always @* begin
    ser_take = lclk_rise && ser_valid && (!busy_ff || bit_cnt_ff == `LTPG_LAST_BIT);
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      shift_ff       <= {NL*S{1'b0}};
      frame_shift_ff <= {S{1'b0}};
      bit_cnt_ff     <= 4'h0;
      busy_ff        <= 1'b0;
      lane_data_o    <= 4'h0;
      frame_lane_o   <= 1'b0;
    end else if (lclk_rise) begin
      if (ser_take) begin
        shift_ff       <= ser_data;
        frame_shift_ff <= frame_word;
        bit_cnt_ff     <= 4'h0;
        busy_ff        <= 1'b1;
        for (l = 0; l < NL; l = l + 1) begin
          lane_data_o[l] <= ser_data[l*S + S-1];
        end
        frame_lane_o   <= frame_word[S-1];
      end else if (busy_ff && bit_cnt_ff != `LTPG_LAST_BIT) begin
        bit_cnt_ff     <= bit_cnt_ff + 4'h1;
        for (l = 0; l < NL; l = l + 1) begin
          shift_ff[l*S +: S] <= {shift_ff[l*S +: S-1], 1'b0};
          lane_data_o[l]     <= shift_ff[l*S + S-2];
        end
        frame_shift_ff <= {frame_shift_ff[S-2:0], 1'b0};
        frame_lane_o   <= frame_shift_ff[S-2];
      end else begin
        // Idle lanes and frame rest low so the next frame edge is clean
        busy_ff      <= 1'b0;
        lane_data_o  <= 4'h0;
        frame_lane_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/ltpg_map.vh ***
// Constants for the LVDS test pattern generator
`ifndef LTPG_MAP_VH
`define LTPG_MAP_VH
// ---------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------
`define LTPG_REG_CTRL        4'h0
`define LTPG_REG_LANE_SEL    4'h4
`define LTPG_REG_CUSTOM      4'h8
`define LTPG_REG_STATUS      4'hC
// ---------------------------------------------------------------
// CTRL fields
// ---------------------------------------------------------------
`define LTPG_CTRL_COMMON_LSB 0
`define LTPG_CTRL_PERLANE    3
`define LTPG_CTRL_GBL_RAND   4
`define LTPG_CTRL_RAND_EN    5
`define LTPG_CTRL_RAND_LEN   6
`define LTPG_CTRL_RAND_RST   7
`define LTPG_CTRL_FRAME_LSB  8
`define LTPG_CTRL_FRAME_RAND 11
`define LTPG_CTRL_SYNC       12
`define LTPG_CTRL_LANE_RAND  16
// ---------------------------------------------------------------
// Pattern codes
// ---------------------------------------------------------------
`define LTPG_PAT_NORMAL      3'h0
`define LTPG_PAT_ZEROS       3'h1
`define LTPG_PAT_ONES        3'h2
`define LTPG_PAT_DESKEW      3'h3
`define LTPG_PAT_SYNC        3'h4
`define LTPG_PAT_CUSTOM      3'h5
`define LTPG_PAT_RAMP        3'h6
`define LTPG_PAT_TOGGLE      3'h7
// ---------------------------------------------------------------
// Sizes and fixed words
// ---------------------------------------------------------------
`define LTPG_LANES           4
`define LTPG_SER             14
`define LTPG_RES             14
`define LTPG_FIFO_DEPTH      8
`define LTPG_DESKEW_WORD     14'h1555
`define LTPG_SYNC_WORD       14'h3F80
`define LTPG_RST_CTRL        32'h0000_0000
`define LTPG_RST_LANE_SEL    32'h0000_0000
`define LTPG_RST_CUSTOM      32'h0000_0000
`define LTPG_PRBS_SEED23     23'h7FFFFF
`define LTPG_PRBS_SEED9      9'h1FF
`define LTPG_LAST_BIT        4'hD
`endif

// *** hw/ltpg_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ltpg_fifo #(
  parameter WIDTH = 56,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);
  reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg  [AW-1:0]    wr_ff;
  reg  [AW-1:0]    rd_ff;
  reg  [AW:0]      cnt_ff;
  wire             do_wr;
  wire             do_rd;

  // Output register counts as a slot only via out_valid_o
  assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
  assign do_wr      = in_valid_i && in_ready_o;
  assign do_rd      = (cnt_ff != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);

  always @(posedge clk_i) begin
    if (do_wr) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ff       <= {AW{1'b0}};
      rd_ff       <= {AW{1'b0}};
      cnt_ff      <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ff       <= rd_ff + 1'b1;
        out_data_o  <= mem_ff[rd_ff];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      cnt_ff <= cnt_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule
`default_nettype wire

// *** dv/ltpg_top_monitor.sv ***
// Assertion checker for the pattern generator's bus and lane timing
`timescale 1ns/1ps
`default_nettype none
`include "ltpg_map.vh"
module ltpg_top_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Register bus
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Samples
  input wire logic [55:0] sample_data_i,
  input wire logic        sample_valid_i,
  input wire logic        sample_ready_o,
  // Link
  input wire logic        link_clk_i,
  input wire logic        transmit_trigger_pin_i,
  input wire logic [3:0]  lane_data_o,
  input wire logic        frame_lane_o
);
  logic [3:0]  lnk_age;
  logic [31:0] ctrl_seen;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i)
      lnk_age <= 4'hF;
    else if ($rose(link_clk_i))
      lnk_age <= 4'h0;
    else if (lnk_age != 4'hF)
      lnk_age <= lnk_age + 4'h1;
  end
  // Pulse-type control bits are masked at compare time, not here
  always @(posedge clk_i) begin
    if (sys_rst_i)
      ctrl_seen <= `LTPG_RST_CTRL;
    else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i == 4'hF
             && avs_address_i == `LTPG_REG_CTRL)
      ctrl_seen <= avs_writedata_i;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence bus_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence bus_done;
    !avs_waitrequest_o;
  endsequence
  wait_one_a: assert property (bus_take |=> bus_done)
    else $error("bus answer not one cycle after request");
  wait_pulse_a: assert property (bus_done |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without a request");
  unmapped_read_a: assert property ((avs_read_i && avs_waitrequest_o && avs_address_i == 4'h2)
    |=> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property ((avs_read_i && avs_waitrequest_o && avs_address_i == `LTPG_REG_CTRL)
    |=> (avs_readdata_o & 32'h000F_0F7F) == (ctrl_seen & 32'h000F_0F7F))
    else $error("control readback differs from last write");
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst_i
    |=> avs_waitrequest_o && avs_readdata_o == 32'h0000_0000 && lane_data_o == 4'h0)
    else $error("outputs not quiet in reset");
  lane_timing_a: assert property ($changed(lane_data_o) |-> lnk_age >= 4'h1 && lnk_age <= 4'h6)
    else $error("lane bit changed away from a link edge");
  frame_timing_a: assert property ($changed(frame_lane_o) |-> lnk_age >= 4'h1 && lnk_age <= 4'h6)
    else $error("frame bit changed away from a link edge");
endmodule
bind ltpg_top ltpg_top_monitor ltpg_top_monitor_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .sample_data_i(sample_data_i),
  .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .link_clk_i(link_clk_i),
  .transmit_trigger_pin_i(transmit_trigger_pin_i), .lane_data_o(lane_data_o), .frame_lane_o(frame_lane_o)
);
`default_nettype wire

// *** dv/ltpg_rx_model.sv ***
// Receiver model: makes the bit clock and deframes the serial lanes
`timescale 1ns/1ps
`default_nettype none
module ltpg_rx_model #(
  parameter int HALF_NS = 100
) (
  // Serial lanes
  input  wire logic [3:0]  lane_data_i,
  input  wire logic        frame_lane_i,
  // Bit clock and deframed words
  output logic             link_clk_o,
  output logic [55:0]      word_o,
  output logic [15:0]      word_cnt_o
);
  logic        prev_fr = 1'b0;
  logic [3:0]  bit_cnt = 4'h0;
  logic [13:0] shreg [4];
  logic [55:0] word_q = 56'h0;
  logic [15:0] cnt_q = 16'h0;
  int          g;
  assign word_o     = word_q;
  assign word_cnt_o = cnt_q;
  // Serializer bit clock runs free; phase kept apart from the system clock
  initial begin
    link_clk_o = 1'b0;
    #37;
    forever #HALF_NS link_clk_o = ~link_clk_o;
  end
  // A rising frame bit marks the first, most significant bit of a word;
  // the word is complete with the fourteenth sample, taken straight from the pins
  always @(posedge link_clk_o) begin
    for (g = 0; g < 4; g++)
      shreg[g] <= {shreg[g][12:0], lane_data_i[g]};
    prev_fr <= frame_lane_i;
    if (frame_lane_i === 1'b1 && prev_fr === 1'b0)
      bit_cnt <= 4'h1;
    else if (bit_cnt == 4'hD) begin
      word_q  <= {shreg[3][12:0], lane_data_i[3], shreg[2][12:0], lane_data_i[2],
                  shreg[1][12:0], lane_data_i[1], shreg[0][12:0], lane_data_i[0]};
      cnt_q   <= cnt_q + 16'h1;
      bit_cnt <= 4'h0;
    end else if (bit_cnt != 4'h0)
      bit_cnt <= bit_cnt + 4'h1;
  end
endmodule
`default_nettype wire

// *** dv/lvds_test_pattern_generator_tb.sv ***
// Self-checking bench for the LVDS test pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "ltpg_map.vh"
module lvds_test_pattern_generator_tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [55:0] smp = 56'h0;
  logic        smp_vld = 1'b0;
  logic        trig = 1'b0;
  wire  [31:0] rdat;
  wire         wreq;
  wire         smp_rdy;
  wire         lnk;
  wire  [3:0]  lanes;
  wire         frame;
  wire  [55:0] word;
  wire  [15:0] wcnt;
  int          n_mismatch = 0;
  int          checked = 0;
  int          nrx = 0;
  logic [55:0] q [$];
  logic [13:0] fix [1:5] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h3F80, 14'h32D7};

  initial forever #12.5 clk_i = ~clk_i;

  ltpg_top ltpg_top_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .sample_data_i(smp), .sample_valid_i(smp_vld), .sample_ready_o(smp_rdy), .link_clk_i(lnk),
    .transmit_trigger_pin_i(trig), .lane_data_o(lanes), .frame_lane_o(frame)
  );
  ltpg_rx_model ltpg_rx_model_inst (
    .lane_data_i(lanes), .frame_lane_i(frame), .link_clk_o(lnk), .word_o(word), .word_cnt_o(wcnt)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [55:0] seen, input logic [55:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fail(input string nm);
    n_mismatch++;
    $display("BAD %s expected answer seen timeout", nm);
    wrap_up();
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (wreq === 1'b0)
        break;
    end
    if (k == 20)
      fail("bus access");
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // Acceptance shows on ready one cycle late, so each offer is a single-cycle pulse
  task automatic push(input logic [55:0] s, input int tries, output logic ok);
    int k;
    ok = 1'b0;
    for (k = 0; k < tries && ok !== 1'b1; k++) begin
      @(posedge clk_i);
      if (smp_rdy === 1'b1) begin
        smp_vld <= 1'b1;
        smp <= s;
        @(posedge clk_i);
        smp_vld <= 1'b0;
        @(posedge clk_i);
        ok = smp_rdy;
      end
    end
    if (tries > 1 && ok !== 1'b1)
      fail("sample accept");
  endtask
  task automatic get_word(output logic [55:0] w);
    int k;
    for (k = 0; k < 4000 && wcnt === 16'(nrx); k++)
      @(posedge clk_i);
    if (wcnt === 16'(nrx))
      fail("link word");
    nrx++;
    w = word;
  endtask
  task automatic drain(input string nm);
    logic [55:0] w;
    while (q.size() > 0) begin
      get_word(w);
      chk(nm, w, q.pop_front());
    end
  endtask
  task automatic trig_pulse;
    @(posedge clk_i);
    trig <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [55:0] s;
    logic [55:0] w0;
    logic [55:0] w;
    logic        ok;
    logic [8:0]  lf;
    int          n;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, `LTPG_REG_CTRL, 32'h0, r);
    chk("ctrl reset", 56'(r), 56'(`LTPG_RST_CTRL));
    bus(1'b0, `LTPG_REG_CUSTOM, 32'h0, r);
    chk("custom reset", 56'(r), 56'(`LTPG_RST_CUSTOM));
    bus(1'b0, 4'h2, 32'h0, r);
    chk("unmapped read", 56'(r), 56'h0);
    // Fill until refused while the link drains slowly, then empty it
    s = 56'h0A55_A03C_3C3C_C3;
    n = 0;
    do begin
      push(s + 56'(n), 1, ok);
      if (ok === 1'b1) begin
        q.push_back(s + 56'(n));
        n++;
      end
    end while (ok === 1'b1 && n < 12);
    chk("fifo depth", 56'(n >= 8 && n <= 10), 56'h1);
    drain("sample word");
    wreg(`LTPG_REG_CUSTOM, 32'h0000_CB5C);
    for (n = 1; n < 6; n++) begin
      wreg(`LTPG_REG_CTRL, 32'(n));
      push(s, 100, ok);
      q.push_back({4{fix[n]}});
      drain("common pattern");
    end
    wreg(`LTPG_REG_LANE_SEL, 32'h0000_011A);
    wreg(`LTPG_REG_CTRL, 32'h0000_0009);
    push(s, 100, ok);
    q.push_back({s[55:42], 14'h3F80, 14'h1555, 14'h3FFF});
    drain("lane pattern");
    wreg(`LTPG_REG_CTRL, 32'h0000_0006);
    trig_pulse();
    for (n = 0; n < 3; n++)
      push(s, 100, ok);
    get_word(w0);
    chk("ramp lanes", w0, {4{w0[13:0]}});
    for (n = 1; n < 3; n++) begin
      get_word(w);
      chk("ramp step", w, {4{w0[13:0] + 14'(n << (`LTPG_SER - `LTPG_RES))}});
    end
    trig_pulse();
    push(s, 100, ok);
    get_word(w);
    chk("ramp restart", w, w0);
    wreg(`LTPG_REG_CTRL, 32'h0000_1007);
    wreg(`LTPG_REG_CTRL, 32'h0000_0007);
    for (n = 0; n < 3; n++) begin
      push(s, 100, ok);
      q.push_back(n == 1 ? {4{14'h3FFF}} : 56'h0);
    end
    drain("toggle word");
    bus(1'b0, `LTPG_REG_STATUS, 32'h0, r);
    chk("status word", 56'(r), 56'({16'h0000, 14'h0003, 1'b1, 1'b0}));
    // Random on all lanes over a custom base, 9-stage generator, then reseed
    wreg(`LTPG_REG_CTRL, 32'h0000_0075);
    wreg(`LTPG_REG_CTRL, 32'h0000_00F5);
    lf = `LTPG_PRBS_SEED9;
    for (n = 0; n < 2; n++) begin
      push(s, 100, ok);
      q.push_back({4{lf, 5'h00}});
      lf = {lf[7:0], lf[8] ^ lf[4]};
    end
    drain("random word");
    // Random on lane 0 only; the reset bit falls and rises again to reseed
    wreg(`LTPG_REG_LANE_SEL, 32'h0000_0115);
    wreg(`LTPG_REG_CTRL, 32'h0001_0068);
    wreg(`LTPG_REG_CTRL, 32'h0001_00E8);
    push(s, 100, ok);
    q.push_back({s[55:42], 14'h3F80, 14'h3FFF, `LTPG_PRBS_SEED9, 5'h00});
    drain("lane random");
    wrap_up();
  end
endmodule
`default_nettype wire
